// ==== hdl/mains_input_pkg.sv ====
// constants and types shared by the mains input function logic
package mains_input_pkg;
  // number of optocoupler inputs
  localparam int unsigned N_IN = 4;
  // clock period and millisecond tick
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  // step-down interval of one second, in ms ticks
  localparam int unsigned STEP_S = 1;
  localparam logic [15:0] STEP_MS = 16'(STEP_S * 1000);
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG0 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // configuration word fields
  localparam int unsigned CFG_FN_LSB = 0;
  localparam int unsigned CFG_FN_W = 4;
  localparam int unsigned CFG_DLY_LSB = 16;
  localparam int unsigned CFG_DLY_W = 16;
  // control word fields
  localparam int unsigned CTRL_FLOW_RST = 0;
  // reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic CTRL_RST = 1'b0;
  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // input function codes
  typedef enum logic [3:0] {
    FN_OFF          = 4'h0,
    FN_LOAD_LIMIT   = 4'h1,
    FN_SECOND_SETPOINT_SELECT_LOW  = 4'h2,
    FN_SECOND_SETPOINT_SELECT_HIGH = 4'h3,
    FN_BACKRUN_LOW  = 4'h4,
    FN_BACKRUN_HIGH = 4'h5,
    FN_LOW_PRESSURE = 4'h6,
    FN_HIGH_PRESSURE = 4'h7,
    FN_ICING_ALARM_FUNCTION = 4'h8,
    FN_FLOW         = 4'h9,
    FN_FEEDBACK     = 4'ha
  } in_func_e;
  // flow reset sequence states
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_BLOCK = 2'b01,
    FL_CHECK = 2'b10,
    FL_TRIP  = 2'b11
  } flow_state_e;
endpackage

// ==== hdl/input_delay_filter.sv ====
// one optocoupler input: synchroniser, polarity and reaction delay
`timescale 1ns/1ns
`default_nettype none
module input_delay_filter (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // millisecond tick
  input  wire logic        ms_tick,
  // configuration
  input  wire logic        enable,
  input  wire logic        act_high,
  input  wire logic [15:0] delay_ms,
  // pin and results
  input  wire logic        pin,
  output logic             sync_lvl,
  output logic             raw_act,
  output logic             filt_act
);
  logic        meta;   // first synchroniser stage
  logic [15:0] cnt;    // elapsed ms of a pending change

  // two flip-flop synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta     <= 1'b0;
      sync_lvl <= 1'b0;
    end else if (ce) begin
      meta     <= pin;
      sync_lvl <= meta;
    end
  end

  // active level from the function polarity, off forces inactive
  always_comb begin
    raw_act = enable & (sync_lvl ~^ act_high);
  end

  // change is taken only after the full delay, a return restarts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt      <= 16'h0000;
      filt_act <= 1'b0;
    end else if (ce) begin
      if (raw_act == filt_act) begin
        cnt <= 16'h0000;
      end else if (cnt >= delay_ms) begin
        filt_act <= raw_act;
        cnt      <= 16'h0000;
      end else if (ms_tick) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule // input_delay_filter
`default_nettype wire

// ==== hdl/step_down_timer.sv ====
// shared one-second step-down pulse generator
`timescale 1ns/1ns
`default_nettype none
module step_down_timer
  import mains_input_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // millisecond tick and request
  input  wire logic ms_tick,
  input  wire logic run,
  // one-cycle step request
  output logic      step
);
  logic [15:0] cnt; // ms left until the next step

  // first step at once, then one per second while requested
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 16'h0000;
      step <= 1'b0;
    end else if (ce) begin
      step <= 1'b0;
      if (!run) begin
        cnt <= 16'h0000;
      end else if (cnt == 16'h0000) begin
        step <= 1'b1;
        cnt  <= STEP_MS;
      end else if (ms_tick) begin
        cnt <= cnt - 16'h0001;
      end
    end
  end
endmodule // step_down_timer
`default_nettype wire

// ==== hdl/mains_input_function_logic.sv ====
// mains optocoupler input functions with ahb-lite register access
`timescale 1ns/1ns
`default_nettype none
module mains_input_function_logic
  import mains_input_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // optocoupler pins, high when mains voltage present
  input  wire logic [3:0]  opto_in,
  // stage sequencer status
  input  wire logic        pump_on,
  input  wire logic        pump_idle_done,
  // requests to sequencer and setpoint logic
  output logic             load_limit,
  output logic             night_mode,
  output logic             forced_backrun,
  output logic             alarm,
  output logic             step_off,
  output logic             stage_block,
  output logic             stages_off,
  output logic             pump_start,
  output logic [3:0]       feedback_ok,
  output logic [3:0]       feedback_used
);

  // ************************************************
  // function decode helpers
  // ************************************************

  // true when the function reacts to voltage present
  function automatic logic fn_high(input logic [3:0] f);
    case (f)
      FN_LOAD_LIMIT, FN_SECOND_SETPOINT_SELECT_HIGH,
      FN_BACKRUN_HIGH, FN_FEEDBACK: fn_high = 1'b1;
      default: fn_high = 1'b0;
    endcase
  endfunction

  // true when the function is a step-down alarm
  function automatic logic fn_alarm(input logic [3:0] f);
    case (f)
      FN_LOW_PRESSURE, FN_HIGH_PRESSURE,
      FN_ICING_ALARM_FUNCTION, FN_FLOW: fn_alarm = 1'b1;
      default: fn_alarm = 1'b0;
    endcase
  endfunction

  // ************************************************
  // registers and bus state
  // ************************************************

  logic [31:0] cfg [N_IN];      // per-input function and delay
  logic        flow_rst_en;     // flow reset option
  logic        wr_pend;         // write data phase pending
  logic [7:0]  wr_addr;         // latched write offset
  logic [16:0] ms_cnt;          // prescaler for ms tick
  logic        ms_tick;         // one pulse per millisecond
  logic [3:0]  sync_lvl;        // synchronised pin levels
  logic [3:0]  raw_act;         // active level before delay
  logic [3:0]  filt_act;        // active level after delay
  flow_state_e flow_st;         // flow reset sequence
  logic [15:0] chk_cnt;         // flow check ms counter
  logic [15:0] flow_dly;        // delay of the flow input
  logic        flow_act;        // filtered flow alarm
  logic        flow_raw;        // undelayed flow alarm
  logic        any_limit;       // limitation or alarm active
  logic        step;            // shared step pulse
  logic        addr_ok;         // valid address phase
  logic [31:0] next_rdata;      // read mux

  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);

  // ************************************************
  // millisecond tick
  // ************************************************

  // prescaler from the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt  <= 17'h00000;
      ms_tick <= 1'b0;
    end else if (ce) begin
      if (ms_cnt >= 17'(MS_TICK_CYCLES - 1)) begin
        ms_cnt  <= 17'h00000;
        ms_tick <= 1'b1;
      end else begin
        ms_cnt  <= ms_cnt + 17'h00001;
        ms_tick <= 1'b0;
      end
    end
  end

  // ************************************************
  // input channels
  // ************************************************

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      input_delay_filter u_flt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .ms_tick  (ms_tick),
        .enable   (cfg[gi][CFG_FN_LSB +: CFG_FN_W] != FN_OFF),
        .act_high (fn_high(cfg[gi][CFG_FN_LSB +: CFG_FN_W])),
        .delay_ms (cfg[gi][CFG_DLY_LSB +: CFG_DLY_W]),
        .pin      (opto_in[gi]),
        .sync_lvl (sync_lvl[gi]),
        .raw_act  (raw_act[gi]),
        .filt_act (filt_act[gi])
      );
    end
  endgenerate

  // ************************************************
  // function combination
  // ************************************************

  logic lim_c, night_c, brun_c, alm_c;
  logic [3:0] fb_c, fbu_c;

  // gather active inputs by function
  always_comb begin
    lim_c    = 1'b0;
    night_c  = 1'b0;
    brun_c   = 1'b0;
    alm_c    = 1'b0;
    flow_act = 1'b0;
    flow_raw = 1'b0;
    flow_dly = 16'h0000;
    fb_c     = 4'h0;
    fbu_c    = 4'h0;
    for (int i = 0; i < N_IN; i++) begin
      case (cfg[i][CFG_FN_LSB +: CFG_FN_W])
        FN_LOAD_LIMIT: lim_c = lim_c | filt_act[i];
        FN_SECOND_SETPOINT_SELECT_LOW,
        FN_SECOND_SETPOINT_SELECT_HIGH: begin
          night_c = night_c | filt_act[i];
        end
        FN_BACKRUN_LOW, FN_BACKRUN_HIGH: begin
          brun_c = brun_c | filt_act[i];
        end
        FN_FLOW: begin
          flow_act = flow_act | filt_act[i];
          flow_raw = flow_raw | raw_act[i];
          flow_dly = cfg[i][CFG_DLY_LSB +: CFG_DLY_W];
        end
        FN_FEEDBACK: begin
          fb_c[i]  = filt_act[i];
          fbu_c[i] = 1'b1;
        end
        default: begin
        end
      endcase
      if (fn_alarm(cfg[i][CFG_FN_LSB +: CFG_FN_W]) &&
          cfg[i][CFG_FN_LSB +: CFG_FN_W] != FN_FLOW) begin
        alm_c = alm_c | filt_act[i];
      end
    end
  end

  // flow alarm counts unless a reset start is being checked
  assign any_limit = lim_c | alm_c |
                     (flow_act & (flow_st != FL_CHECK));

  // ************************************************
  // shared step-down sequence
  // ************************************************

  step_down_timer u_step (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .ms_tick (ms_tick),
    .run     (any_limit),
    .step    (step)
  );

  // ************************************************
  // flow reset sequence
  // ************************************************

  // pump is assumed excluded pump one when flow is assigned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_st    <= FL_IDLE;
      chk_cnt    <= 16'h0000;
      pump_start <= 1'b0;
    end else if (ce) begin
      pump_start <= 1'b0;
      case (flow_st)
        FL_IDLE: begin
          if (flow_act && !pump_on) begin
            flow_st <= FL_BLOCK;
          end
        end
        FL_BLOCK: begin
          if (!flow_act) begin
            flow_st <= FL_IDLE;
          end else if (flow_rst_en && pump_idle_done) begin
            pump_start <= 1'b1;
            chk_cnt    <= 16'h0000;
            flow_st    <= FL_CHECK;
          end
        end
        FL_CHECK: begin
          if (chk_cnt >= flow_dly) begin
            flow_st <= flow_raw ? FL_TRIP : FL_IDLE;
          end else if (ms_tick) begin
            chk_cnt <= chk_cnt + 16'h0001;
          end
        end
        FL_TRIP: begin
          if (!flow_act) begin
            flow_st <= FL_IDLE;
          end
        end
        default: flow_st <= FL_IDLE;
      endcase
    end
  end

  // ************************************************
  // registered outputs to sequencer
  // ************************************************

  // all requests leave from flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_limit     <= 1'b0;
      night_mode     <= 1'b0;
      forced_backrun <= 1'b0;
      alarm          <= 1'b0;
      step_off       <= 1'b0;
      stage_block    <= 1'b0;
      stages_off     <= 1'b0;
      feedback_ok    <= 4'h0;
      feedback_used  <= 4'h0;
    end else if (ce) begin
      load_limit     <= lim_c;
      night_mode     <= night_c;
      forced_backrun <= brun_c;
      alarm          <= alm_c | flow_act;
      step_off       <= step;
      stage_block    <= (flow_st == FL_BLOCK) |
                        (flow_st == FL_TRIP);
      stages_off     <= (flow_st == FL_TRIP);
      feedback_ok    <= fb_c;
      feedback_used  <= fbu_c;
    end
  end

  // ************************************************
  // ahb-lite slave
  // ************************************************

  // always ready, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // address phase of a write is latched for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        wr_pend <= addr_ok & hwrite;
        wr_addr <= haddr[7:0];
      end
    end
  end

  // control register written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_rst_en <= CTRL_RST;
    end else if (ce) begin
      if (wr_pend && wr_addr == OFS_CTRL) begin
        flow_rst_en <= hwdata[CTRL_FLOW_RST];
      end
    end
  end

  // per-input configuration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N_IN; i++) begin
        cfg[i] <= CFG_RST;
      end
    end else if (ce) begin
      for (int i = 0; i < N_IN; i++) begin
        if (wr_pend && wr_addr == OFS_CFG0 + 8'(4 * i)) begin
          cfg[i] <= {hwdata[31:16], 12'h000, hwdata[3:0]};
        end
      end
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr[7:0] == OFS_CTRL) begin
      next_rdata[CTRL_FLOW_RST] = flow_rst_en;
    end else if (haddr[7:0] == OFS_STAT) begin
      next_rdata = {18'h00000, flow_st, raw_act, filt_act, sync_lvl};
    end
    for (int i = 0; i < N_IN; i++) begin
      if (haddr[7:0] == OFS_CFG0 + 8'(4 * i)) begin
        next_rdata = cfg[i];
      end
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule // mains_input_function_logic
`default_nettype wire

// ==== test/mains_input_monitor.sv ====
// checker for the mains input function outputs
`timescale 1ns/1ns
`default_nettype none
module mains_input_monitor (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // sequencer status
  input wire logic       pump_idle_done,
  // function outputs
  input wire logic       load_limit,
  input wire logic       alarm,
  input wire logic       step_off,
  input wire logic       stage_block,
  input wire logic       stages_off,
  input wire logic       pump_start,
  input wire logic [3:0] feedback_ok,
  input wire logic [3:0] feedback_used
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // feedback is reported only on inputs set up as feedback
  a_feedback_used: assert property ((feedback_ok & ~feedback_used) == 4'h0)
    else $error("feedback seen on a non-feedback input");
  // a step needs a limitation or alarm just before it
  a_step_cause: assert property (step_off |-> $past(load_limit || alarm) || $past(load_limit || alarm, 2))
    else $error("step without cause");
  // steps never come back to back
  a_step_gap: assert property (step_off |=> !step_off [*8])
    else $error("steps too close");
  // no cause for three cycles means no step
  a_idle_step: assert property (!(load_limit || alarm) [*3] |-> !step_off)
    else $error("step while idle");
  // pump start only once its idle time is over
  a_pump_src: assert property (pump_start |-> $past(pump_idle_done))
    else $error("pump start before idle time");
  // pump start is a single pulse
  a_pump_pulse: assert property (pump_start |=> !pump_start)
    else $error("pump start too long");
  // a failed flow check also blocks stages
  a_trip_block: assert property (stages_off |-> stage_block)
    else $error("stages off without block");
  // blocking follows an alarm
  a_block_cause: assert property ($rose(stage_block) |-> alarm || $past(alarm))
    else $error("block without alarm");
endmodule // mains_input_monitor
bind mains_input_function_logic mains_input_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .pump_idle_done(pump_idle_done), .load_limit(load_limit),
  .alarm(alarm), .step_off(step_off), .stage_block(stage_block), .stages_off(stages_off),
  .pump_start(pump_start), .feedback_ok(feedback_ok), .feedback_used(feedback_used));
`default_nettype wire

// ==== test/field_contacts.sv ====
// field contacts and pump seen by the optocoupler inputs
`timescale 1ns/1ns
`default_nettype none
module field_contacts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // contact states, 1 = mains present
  input wire logic  [3:0] volt,
  // pump control
  input wire logic        pump_start,
  input wire logic        pump_stop,
  // to the device
  output logic      [3:0] opto_in,
  output logic            pump_on
);
  // contacts drive mains straight onto the pins
  assign opto_in = volt;
  // machine 1 is a pump kept out of sequencing, started by the flow reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pump_on <= 1'b0;
    end else if (pump_stop) begin
      pump_on <= 1'b0;
    end else if (pump_start) begin
      pump_on <= 1'b1;
    end
  end
endmodule // field_contacts
`default_nettype wire

// ==== test/tb_mains_input_function_logic.sv ====
// testbench for the mains input function logic
`timescale 1ns/1ns
`default_nettype none
module tb_mains_input_function_logic;
  import mains_input_pkg::*;
  // ****************
  // signals
  // ****************
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, pump_on, pump_idle_done = 1'b0, pump_stop = 1'b0;
  logic [3:0]  volt = 4'hf, opto_in, feedback_ok, feedback_used;
  logic        load_limit, night_mode, forced_backrun, alarm, step_off, stage_block, stages_off, pump_start;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // clock of 8 ns
  always #4 hclk = ~hclk;
  mains_input_function_logic #(.MS_TICK_CYCLES(10)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .opto_in(opto_in), .pump_on(pump_on),
    .pump_idle_done(pump_idle_done), .load_limit(load_limit), .night_mode(night_mode),
    .forced_backrun(forced_backrun), .alarm(alarm), .step_off(step_off), .stage_block(stage_block),
    .stages_off(stages_off), .pump_start(pump_start), .feedback_ok(feedback_ok),
    .feedback_used(feedback_used));
  field_contacts u_field (.hclk(hclk), .hresetn(hresetn), .volt(volt), .pump_start(pump_start),
    .pump_stop(pump_stop), .opto_in(opto_in), .pump_on(pump_on));
  // ****************
  // helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      $display("FAIL %s expected %h seen %h", nm, ex, got);
      n_mismatch++;
    end
  endtask
  // one ahb-lite single word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cfg(input int i, input logic [15:0] d, input logic [3:0] f);
    logic [31:0] r;
    bus(1'b1, OFS_CFG0 + 8'(4 * i), {d, 12'h0, f}, r);
  endtask
  // bounded wait for a level, then judged
  task automatic wait_hi(ref logic s, input int n, input string nm);
    for (int i = 0; i < n && s !== 1'b1; i++) cyc(1);
    chk(nm, 32'h1, {31'h0, s});
  endtask
  // output that belongs to a function code
  function automatic logic sel(input int f);
    case (f)
      1: sel = load_limit;
      2, 3: sel = night_mode;
      4, 5: sel = forced_backrun;
      6, 7, 8, 9: sel = alarm;
      10: sel = feedback_ok[0];
      default: sel = load_limit | night_mode | forced_backrun | alarm | feedback_ok[0];
    endcase
  endfunction
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    logic [31:0] r;
    chk("outputs", 32'h0, {25'h0, load_limit, night_mode, forced_backrun, alarm, step_off, stage_block, stages_off});
    chk("ready", 32'h1, {31'h0, hreadyout});
    chk("resp", 32'h0, {31'h0, hresp});
    bus(1'b0, OFS_CTRL, 32'h0, r);
    chk("ctrl", {31'h0, CTRL_RST}, r);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, OFS_CFG0 + 8'(4 * i), 32'h0, r);
      chk("cfg", CFG_RST, r);
    end
    bus(1'b1, OFS_CFG0, 32'hffff_fffa, r);
    bus(1'b0, OFS_CFG0, 32'h0, r);
    chk("cfg_mask", 32'hffff_000a, r);
    cfg(0, 16'h0, 4'h0);
    bus(1'b1, OFS_STAT, 32'hffff_ffff, r);
    bus(1'b0, OFS_STAT, 32'h0, r);
    chk("stat_ro", 32'h0000_000f, r);
    bus(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("regs test done");
  endtask
  // clock enable low must hold every state, high lets it run on
  task automatic t_freeze;
    volt[2] <= 1'b0;
    cfg(2, 16'h0, 4'h1);
    cyc(8);
    ce <= 1'b0;
    volt[2] <= 1'b1;
    cyc(20);
    chk("frozen", 32'h0, {31'h0, load_limit});
    ce <= 1'b1;
    wait_hi(load_limit, 10, "thawed");
    cfg(2, 16'h0, 4'h0);
    cyc(8);
    chk("freeze_off", 32'h0, {31'h0, load_limit});
    $display("freeze test done");
  endtask
  task automatic t_func;
    logic hi;
    for (int f = 0; f <= 10; f++) begin
      hi = (f == 1 || f == 3 || f == 5 || f == 10);
      cfg(0, 16'h0, 4'(f));
      volt[0] <= 1'b1;
      cyc(8);
      chk("fn_volt", {31'h0, hi && f != 0}, {31'h0, sel(f)});
      volt[0] <= 1'b0;
      cyc(8);
      chk("fn_novolt", {31'h0, !hi && f != 0}, {31'h0, sel(f)});
      chk("fb_used", {31'h0, f == 10}, {31'h0, feedback_used[0]});
    end
    cfg(0, 16'h0, 4'h0);
    $display("function test done");
  endtask
  task automatic t_delay;
    cfg(1, 16'd5, 4'h6);
    volt[1] <= 1'b0;
    cyc(30);
    volt[1] <= 1'b1;
    cyc(4);
    volt[1] <= 1'b0;
    cyc(30);
    volt[1] <= 1'b1;
    cyc(20);
    chk("glitch", 32'h0, {31'h0, alarm});
    volt[1] <= 1'b0;
    cyc(40);
    chk("early", 32'h0, {31'h0, alarm});
    wait_hi(alarm, 40, "delayed");
    $display("delay test done");
  endtask
  task automatic t_step;
    int n;
    wait_hi(step_off, 10, "first_step");
    cyc(1);
    volt[0] <= 1'b1;
    cfg(0, 16'h0, 4'h1);
    n = 0;
    for (int i = 0; i < 9900; i++) begin
      cyc(1);
      n += int'(step_off === 1'b1);
    end
    chk("shared_seq", 32'h0, 32'(n));
    n = 0;
    for (int i = 0; i < 200; i++) begin
      cyc(1);
      n += int'(step_off === 1'b1);
    end
    chk("next_step", 32'h1, 32'(n));
    cfg(0, 16'h0, 4'h0);
    cfg(1, 16'h0, 4'h0);
    volt[1] <= 1'b1;
    $display("step test done");
  endtask
  task automatic t_flow;
    logic [31:0] r;
    int n;
    cfg(3, 16'd3, 4'h9);
    pump_idle_done <= 1'b1;
    volt[3] <= 1'b0;
    wait_hi(stage_block, 100, "block");
    n = 0;
    for (int i = 0; i < 50; i++) begin
      cyc(1);
      n += int'(pump_start === 1'b1);
    end
    chk("no_reset_start", 32'h0, 32'(n));
    bus(1'b1, OFS_CTRL, 32'h1, r);
    wait_hi(pump_start, 20, "reset_start");
    cyc(15);
    chk("check_wait", 32'h0, {31'h0, stages_off});
    wait_hi(stages_off, 40, "trip");
    chk("trip_block", 32'h1, {31'h0, stage_block});
    bus(1'b0, OFS_STAT, 32'h0, r);
    chk("flow_state", 32'h3, {30'h0, r[13:12]});
    volt[3] <= 1'b1;
    pump_stop <= 1'b1;
    for (int i = 0; i < 100 && stage_block !== 1'b0; i++) cyc(1);
    chk("released", 32'h0, {30'h0, stage_block, stages_off});
    pump_stop <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0, r);
    $display("flow test done");
  endtask
  // ****************
  // run control
  // ****************
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence after six reset cycles
  initial begin
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_freeze;
    t_func;
    t_delay;
    t_step;
    t_flow;
    final_report;
  end
  // watchdog well beyond the expected run
  initial begin
    cyc(30000);
    n_mismatch++;
    final_report;
  end
endmodule // tb_mains_input_function_logic
`default_nettype wire
